// ==== hdl/mbt_avg_filter.v ====
/*
 * exponential weighted-average filter, one per channel or rank.
 * assumes an input weight each clock and a log2 shift below 32.
 */
`timescale 1ns/1ps
module mbt_avg_filter #(
    parameter WW = 9
) (
    input  wire          clk,
    input  wire          resetn,
    input  wire [WW-1:0] weightIn,
    input  wire [4:0]    shift,
    output wire [7:0]    avgOut
);
    // ****************************************************************
    // accumulator holds average scaled by 2^shift
    // ****************************************************************
    reg  [63:0] acc_q;
    wire [63:0] acc_d;
    wire [63:0] decay;
    wire [63:0] avgFull;

    assign decay   = acc_q >> shift;
    assign acc_d   = acc_q - decay + {{(64-WW){1'b0}}, weightIn};
    assign avgFull = acc_q >> shift;
    assign avgOut  = (avgFull > 64'h00000000000000ff) ? 8'hff : avgFull[7:0];

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= 64'h0000000000000000;
        end else begin
            acc_q <= acc_d;
        end
    end
endmodule // mbt_avg_filter

// ==== hdl/mbt_consts.vh ====
/*
 * constants for the memory bandwidth throttle: register offsets, field positions,
 * reset values, filter time constants and memory bus command codes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef MBT_CONSTS_VH
`define MBT_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define MBT_OFF_CH_WEIGHTS   12'h2a0
`define MBT_OFF_CH_CTRL      12'h2a4
`define MBT_OFF_RK_PASSIVE   12'h2a8
`define MBT_OFF_RK_ACTIVE_LO 12'h2ac
`define MBT_OFF_RK_ACTIVE_HI 12'h2b0
`define MBT_OFF_RK_CTRL      12'h2b4

// ****************************************************************
// reset values
// ****************************************************************
`define MBT_RST_WORD 32'h00000000

// ****************************************************************
// field positions
// ****************************************************************
`define MBT_CH_LOCK_BIT   31
`define MBT_CH_TEST_BIT   29
`define MBT_RK_LOCK_BIT   23
`define MBT_RK_TEST_BIT   22
`define MBT_BW_EN_BIT     21
`define MBT_TRIP_EN_BIT   20
`define MBT_CH_CTRL_MASK  32'ha037ffff
`define MBT_RK_CTRL_MASK  32'h00f7ffff
`define MBT_RK_ACT_HI_MSK 32'h0000ffff

// ****************************************************************
// filter time constants as log2 of clocks
// ****************************************************************
`define MBT_LOG2_TEST     5'd7
`define MBT_CH_LOG2_BASE  5'd28
`define MBT_RK_LOG2_BASE  5'd28

// ****************************************************************
// command codes on the memory bus
// ****************************************************************
`define MBT_CMD_NONE  3'h0
`define MBT_CMD_READ  3'h1
`define MBT_CMD_WRITE 3'h2
`define MBT_CMD_PREA  3'h3
`define MBT_CMD_PRE   3'h4
`define MBT_CMD_ACT   3'h5
`define MBT_CMD_REF   3'h6
`define MBT_CMD_OTHER 3'h7

`endif

// ==== hdl/mbt_limit_cmp.v ====
/*
 * limit selection and compare for one filter.
 * assumes synchronised trip input and register-level enables.
 */
`timescale 1ns/1ps
module mbt_limit_cmp (
    input  wire       bwEn,
    input  wire       tripEn,
    input  wire       thermTrip,
    input  wire       tripNeedsAvg,
    input  wire [7:0] avg,
    input  wire [7:0] bwLimit,
    input  wire [7:0] thLimit,
    output wire       block
);
    wire thermMode;
    wire overBw;
    wire overTh;

    // ****************************************************************
    // thermal limit overrides bandwidth limit on a trip
    // ****************************************************************
    assign thermMode = tripEn & thermTrip;
    assign overBw    = avg >= bwLimit;
    assign overTh    = avg >= thLimit;
    assign block     = thermMode ? (tripNeedsAvg ? overTh : overTh | ~bwEn | overTh)
                                 : (bwEn & overBw);
endmodule // mbt_limit_cmp

// ==== hdl/mbt_throttle.v ====
/*
 * memory bandwidth and thermal throttle for one channel: ahb-lite register
 * slave, channel filter, four rank filters and limit compares.
 * assumes command, rank, odt and page state inputs come from the scheduler on
 * clk; the thermal trip is asynchronous and is synchronised here.
 */
//
// Overview of operation
// - read command feeds channel read weight
// - write command feeds channel write weight
// - other command feeds other-command weight
// - idle weight when no command, zero tristated
// - channel lock makes channel registers read-only
// - test mode shortens window to 2^7
// - bandwidth limit compared, thermal on trip
// - trip starts thermal throttling when enabled
// - channel constant 2^28 down to 2^25
// - block at or above bandwidth limit
// - block at or above thermal limit
// - four rank filters, own weights only
// - odt adds its weight to rank
// - open page active background weight
// - precharged active background weight
// - precharged powerdown background weight
// - command weight added to rank background
// - rank read and write weights
// - separate precharge, activate, refresh weights
// - rank lock makes rank registers read-only
// - rank bandwidth limit, thermal on trip
// - rank trip needs filter at or above thermal limit
// - rank constant 2^28 up to 2^31
// - rank over limit blocks memory bus
//
`timescale 1ns/1ps
`include "mbt_consts.vh"
module mbt_throttle #(
    parameter RANKS = 4
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             hsel,
    input  wire [11:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output reg  [31:0]      hrdata,
    output reg              hreadyout,
    output reg              hresp,
    input  wire [2:0]       memCmd,
    input  wire             cmdTristate,
    input  wire [RANKS-1:0] chipSelectN,
    input  wire [RANKS-1:0] odtOn,
    input  wire [RANKS-1:0] pageOpen,
    input  wire [RANKS-1:0] powerDown,
    input  wire             thermTripPin,
    input  wire             isochReq,
    output reg              throttleStall,
    output reg              isochStall
);
    // ****************************************************************
    // registers
    // ****************************************************************
    reg  [31:0] chWeights_q;
    reg  [31:0] chCtrl_q;
    reg  [31:0] rkPassive_q;
    reg  [31:0] rkActLo_q;
    reg  [31:0] rkActHi_q;
    reg  [31:0] rkCtrl_q;
    reg  [11:0] addr_q;
    reg         wrPend_q;
    reg  [1:0]  tripSync_q;
    wire        thermTrip = tripSync_q[1];
    wire        chLocked  = chCtrl_q[`MBT_CH_LOCK_BIT];
    wire        rkLocked  = rkCtrl_q[`MBT_RK_LOCK_BIT];
    wire        takeXfer  = hsel & htrans[1] & hready;

    // ****************************************************************
    // ahb-lite slave, zero wait states, always okay
    // ****************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q      <= 12'h000;
            wrPend_q    <= 1'b0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= `MBT_RST_WORD;
            chWeights_q <= `MBT_RST_WORD;
            chCtrl_q    <= `MBT_RST_WORD;
            rkPassive_q <= `MBT_RST_WORD;
            rkActLo_q   <= `MBT_RST_WORD;
            rkActHi_q   <= `MBT_RST_WORD;
            rkCtrl_q    <= `MBT_RST_WORD;
        end else begin
            wrPend_q <= takeXfer & hwrite;
            addr_q   <= takeXfer ? {haddr[11:2], 2'b00} : addr_q;
            if (takeXfer & !hwrite) begin
                case ({haddr[11:2], 2'b00})
                    `MBT_OFF_CH_WEIGHTS:   hrdata <= chWeights_q;
                    `MBT_OFF_CH_CTRL:      hrdata <= chCtrl_q;
                    `MBT_OFF_RK_PASSIVE:   hrdata <= rkPassive_q;
                    `MBT_OFF_RK_ACTIVE_LO: hrdata <= rkActLo_q;
                    `MBT_OFF_RK_ACTIVE_HI: hrdata <= rkActHi_q;
                    `MBT_OFF_RK_CTRL:      hrdata <= rkCtrl_q;
                    default:               hrdata <= `MBT_RST_WORD;
                endcase
            end
            if (wrPend_q) begin
                case (addr_q)
                    `MBT_OFF_CH_WEIGHTS: begin
                        if (!chLocked) chWeights_q <= hwdata;
                    end
                    `MBT_OFF_CH_CTRL: begin
                        if (!chLocked) chCtrl_q <= hwdata & `MBT_CH_CTRL_MASK;
                    end
                    `MBT_OFF_RK_PASSIVE: begin
                        if (!rkLocked) rkPassive_q <= hwdata;
                    end
                    `MBT_OFF_RK_ACTIVE_LO: begin
                        if (!rkLocked) rkActLo_q <= hwdata;
                    end
                    `MBT_OFF_RK_ACTIVE_HI: begin
                        if (!rkLocked) rkActHi_q <= hwdata & `MBT_RK_ACT_HI_MSK;
                    end
                    `MBT_OFF_RK_CTRL: begin
                        if (!rkLocked) rkCtrl_q <= hwdata & `MBT_RK_CTRL_MASK;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // thermal trip synchroniser
    // ****************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tripSync_q <= 2'b00;
        end else begin
            tripSync_q <= {tripSync_q[0], thermTripPin};
        end
    end

    // ****************************************************************
    // channel filter input weight
    // ****************************************************************
    reg [7:0] chWeight;
    always @* begin
        if (cmdTristate) begin
            chWeight = 8'h00;
        end else begin
            case (memCmd)
                `MBT_CMD_NONE:  chWeight = chWeights_q[7:0];
                `MBT_CMD_READ:  chWeight = chWeights_q[31:24];
                `MBT_CMD_WRITE: chWeight = chWeights_q[23:16];
                default:        chWeight = chWeights_q[15:8];
            endcase
        end
    end

    // ****************************************************************
    // time constants
    // ****************************************************************
    wire [2:0] chTc = chCtrl_q[18:16];
    wire [2:0] rkTc = rkCtrl_q[18:16];
    wire [4:0] chShift = chCtrl_q[`MBT_CH_TEST_BIT] ? `MBT_LOG2_TEST
                       : (`MBT_CH_LOG2_BASE - {3'b000, chTc[1:0]});
    wire [4:0] rkShift = rkCtrl_q[`MBT_RK_TEST_BIT] ? `MBT_LOG2_TEST
                       : (`MBT_RK_LOG2_BASE + {3'b000, rkTc[1:0]});

    wire [7:0] chAvg;
    wire       chBlock;
    mbt_avg_filter #(.WW(8)) u_ch_filter (
        .clk      (clk),
        .resetn   (resetn),
        .weightIn (chWeight),
        .shift    (chShift),
        .avgOut   (chAvg)
    );

    mbt_limit_cmp u_ch_cmp (
        .bwEn         (chCtrl_q[`MBT_BW_EN_BIT]),
        .tripEn       (chCtrl_q[`MBT_TRIP_EN_BIT]),
        .thermTrip    (thermTrip),
        .tripNeedsAvg (1'b1),
        .avg          (chAvg),
        .bwLimit      (chCtrl_q[15:8]),
        .thLimit      (chCtrl_q[7:0]),
        .block        (chBlock)
    );

    // ****************************************************************
    // rank filters
    // ****************************************************************
    wire [RANKS-1:0] rkBlock;
    genvar r;
    generate
        for (r = 0; r < RANKS; r = r + 1) begin : g_rank
            reg  [7:0] bgW;
            reg  [7:0] cmdW;
            wire [9:0] sumW;
            wire [7:0] rkAvg;
            always @* begin
                if (!pageOpen[r] && powerDown[r]) bgW = rkPassive_q[7:0];
                else if (pageOpen[r])             bgW = rkPassive_q[23:16];
                else                              bgW = rkPassive_q[15:8];
                cmdW = 8'h00;
                if (!chipSelectN[r]) begin
                    case (memCmd)
                        `MBT_CMD_READ:  cmdW = rkActHi_q[15:8];
                        `MBT_CMD_WRITE: cmdW = rkActHi_q[7:0];
                        `MBT_CMD_PREA:  cmdW = rkActLo_q[31:24];
                        `MBT_CMD_PRE:   cmdW = rkActLo_q[23:16];
                        `MBT_CMD_ACT:   cmdW = rkActLo_q[15:8];
                        `MBT_CMD_REF:   cmdW = rkActLo_q[7:0];
                        default:        cmdW = 8'h00;
                    endcase
                end
            end
            assign sumW = {2'b00, bgW} + {2'b00, cmdW}
                        + (odtOn[r] ? {2'b00, rkPassive_q[31:24]} : 10'h000);
            mbt_avg_filter #(.WW(10)) u_rk_filter (
                .clk      (clk),
                .resetn   (resetn),
                .weightIn (sumW),
                .shift    (rkShift),
                .avgOut   (rkAvg)
            );
            mbt_limit_cmp u_rk_cmp (
                .bwEn         (rkCtrl_q[`MBT_BW_EN_BIT]),
                .tripEn       (rkCtrl_q[`MBT_TRIP_EN_BIT]),
                .thermTrip    (thermTrip),
                .tripNeedsAvg (1'b1),
                .avg          (rkAvg),
                .bwLimit      (rkCtrl_q[15:8]),
                .thLimit      (rkCtrl_q[7:0]),
                .block        (rkBlock[r])
            );
        end
    endgenerate

    // ****************************************************************
    // stall outputs
    // ****************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            throttleStall <= 1'b0;
            isochStall    <= 1'b0;
        end else begin
            throttleStall <= chBlock | (|rkBlock);
            isochStall    <= (|rkBlock) & isochReq;
        end
    end
endmodule // mbt_throttle

// ==== tb/mbt_dram_model.sv ====
/* ranks and command lines on the memory bus.
   assumes the bench sets requests after a clock edge. */
`timescale 1ns/1ps
`include "mbt_consts.vh"
module mbt_dram_model (
    input  wire       clk,
    input  wire [2:0] cmdReq,
    input  wire [1:0] rankReq,
    input  wire       floatReq,
    input  wire [3:0] odtReq,
    input  wire [3:0] pageReq,
    input  wire [3:0] pdReq,
    output reg  [2:0] memCmd = 3'h0,
    output reg        cmdTristate = 1'b0,
    output reg  [3:0] chipSelectN = 4'hf,
    output reg  [3:0] odtOn = 4'h0,
    output reg  [3:0] pageOpen = 4'h0,
    output reg  [3:0] powerDown = 4'h0
);
    // ****************
    // bus drive
    // ****************
    always @(posedge clk) begin
        cmdTristate <= floatReq;
        memCmd <= floatReq ? ~memCmd : cmdReq;
        chipSelectN <= (floatReq || cmdReq == `MBT_CMD_NONE) ? 4'hf : ~(4'h1 << rankReq);
        odtOn <= odtReq;
        pageOpen <= pageReq;
        powerDown <= pdReq;
    end
endmodule // mbt_dram_model

// ==== tb/mbt_throttle_sva.sv ====
/* checker for the throttle block, seen from its top ports only.
   assumes single word ahb-lite transfers and hready tied to hreadyout. */
`timescale 1ns/1ps
`include "mbt_consts.vh"
module mbt_throttle_sva #(
    parameter RANKS = 4
) (
    input wire        clk,
    input wire        resetn,
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        thermTripPin,
    input wire        throttleStall,
    input wire        isochStall
);
    // ****************
    // register shadows
    // ****************
    reg        wrPend_q;
    reg [11:0] wrAddr_q;
    reg [31:0] chW_q, chC_q, rkP_q, rkC_q;
    wire       take = hsel && htrans[1] && hready;
    wire       rdTake = take && !hwrite;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 12'h000;
            chW_q <= 32'h0;
            chC_q <= 32'h0;
            rkP_q <= 32'h0;
            rkC_q <= 32'h0;
        end else begin
            wrPend_q <= take && hwrite;
            wrAddr_q <= haddr;
            if (wrPend_q && hready) begin
                if (wrAddr_q == `MBT_OFF_CH_WEIGHTS && !chC_q[31]) chW_q <= hwdata;
                if (wrAddr_q == `MBT_OFF_CH_CTRL && !chC_q[31]) chC_q <= hwdata & `MBT_CH_CTRL_MASK;
                if (wrAddr_q == `MBT_OFF_RK_PASSIVE && !rkC_q[23]) rkP_q <= hwdata;
                if (wrAddr_q == `MBT_OFF_RK_CTRL && !rkC_q[23]) rkC_q <= hwdata & `MBT_RK_CTRL_MASK;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ****************
    // assertions
    // ****************
    a_bus_okay:
        assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    a_ch_weight_read:
        assert property (rdTake && haddr == `MBT_OFF_CH_WEIGHTS |=> hrdata == chW_q)
        else $error("channel weights read wrong");
    a_ch_ctrl_read:
        assert property (rdTake && haddr == `MBT_OFF_CH_CTRL |=> hrdata == chC_q)
        else $error("channel control read wrong");
    a_rk_weight_read:
        assert property (rdTake && haddr == `MBT_OFF_RK_PASSIVE |=> hrdata == rkP_q)
        else $error("rank weights read wrong");
    a_rk_ctrl_read:
        assert property (rdTake && haddr == `MBT_OFF_RK_CTRL |=> hrdata == rkC_q)
        else $error("rank control read wrong");
    a_ch_zero_limit:
        assert property ((chC_q[21] && !chC_q[20] && chC_q[15:8] == 8'h00) [*4] |-> throttleStall)
        else $error("zero limit does not stall");
    a_no_enable:
        assert property ((chC_q[21:20] == 2'b00 && rkC_q[21:20] == 2'b00) [*4]
            |-> !throttleStall && !isochStall) else $error("stall with throttling off");
    a_ch_isoch_free:
        assert property ((rkC_q[21:20] == 2'b00) [*4] |-> !isochStall)
        else $error("isoch stalled by channel");
    a_rk_trip_needed:
        assert property ((rkC_q[20] && !rkC_q[21] && !thermTripPin) [*6] |-> !isochStall)
        else $error("rank stall without trip");
endmodule // mbt_throttle_sva
bind mbt_throttle mbt_throttle_sva #(.RANKS(RANKS)) u_mbt_throttle_sva (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .thermTripPin(thermTripPin),
    .throttleStall(throttleStall), .isochStall(isochStall));

// ==== tb/mbt_throttle_tb.sv ====
/* self-checking bench for the throttle block.
   assumes the dram model and the checker bind are compiled alongside. */
`timescale 1ns/1ps
`include "mbt_consts.vh"
module mbt_throttle_tb;
    reg          clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, isochReq = 1'b0;
    reg          thermTripPin = 1'b0, fltR = 1'b0;
    reg  [11:0]  haddr = 12'h000;
    reg  [1:0]   htrans = 2'h0, rkR = 2'h0, probeKind = 2'h0;
    reg  [2:0]   hsize = 3'h2, cmdR = 3'h0;
    reg  [31:0]  hwdata = 32'h0, rnd, seen, w, d;
    reg  [3:0]   odtR = 4'h0, pgR = 4'h0, pdR = 4'h0;
    wire [31:0]  hrdata;
    wire         hreadyout, hresp, cmdTristate, throttleStall, isochStall;
    wire [2:0]   memCmd;
    wire [3:0]   chipSelectN, odtOn, pageOpen, powerDown;
    logic [31:0] expQ [$];
    int          mismatches = 0, samplesChecked = 0, i, s, r;
    string       nm [0:3] = '{"none", "hrdata", "throttleStall", "isochStall"};
    reg  [11:0]  adr [0:6] = '{`MBT_OFF_CH_WEIGHTS, `MBT_OFF_CH_CTRL, `MBT_OFF_RK_PASSIVE,
        `MBT_OFF_RK_ACTIVE_LO, `MBT_OFF_RK_ACTIVE_HI, `MBT_OFF_RK_CTRL, 12'h2b8};
    reg  [31:0]  msk [0:6] = '{32'hffffffff, 32'ha037ffff, 32'hffffffff, 32'hffffffff,
        32'h0000ffff, 32'h00f7ffff, 32'h0};
    reg  [31:0]  lkExp [0:6] = '{32'h40201008, 32'h80200000, 32'h04302010, 32'h18142838,
        32'h00005048, 32'h00800000, 32'h0};
    reg  [15:0]  cs [0:18] = '{16'h0008, 16'h1040, 16'h2020, 16'h3010, 16'h4010, 16'h5010,
        16'h6010, 16'h7010, 16'h0100, 16'h8430, 16'h8020, 16'h8210, 16'h9070, 16'ha068,
        16'hb038, 16'hc034, 16'hd048, 16'he058, 16'h8c34};
    reg  [3:0]   thStep [0:3] = '{4'hf, 4'hc, 4'h4, 4'h2};

    mbt_throttle u_mbt_throttle (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memCmd(memCmd),
        .cmdTristate(cmdTristate), .chipSelectN(chipSelectN), .odtOn(odtOn),
        .pageOpen(pageOpen), .powerDown(powerDown), .thermTripPin(thermTripPin),
        .isochReq(isochReq), .throttleStall(throttleStall), .isochStall(isochStall));
    mbt_dram_model u_mbt_dram_model (.clk(clk), .cmdReq(cmdR), .rankReq(rkR),
        .floatReq(fltR), .odtReq(odtR), .pageReq(pgR), .pdReq(pdR), .memCmd(memCmd),
        .cmdTristate(cmdTristate), .chipSelectN(chipSelectN), .odtOn(odtOn),
        .pageOpen(pageOpen), .powerDown(powerDown));

    // ****************
    // clock, tasks, monitor
    // ****************
    initial forever #2.5 clk = ~clk;
    task ahb(input wr, input [11:0] a, input [31:0] dt, input [31:0] e);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= dt;
        if (!wr) begin
            expQ.push_back(e);
            probeKind <= 2'h1;
        end
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        probeKind <= 2'h0;
    endtask
    task chk(input [1:0] k, input [31:0] e);
        @(posedge clk);
        rnd = $urandom;
        isochReq <= rnd[0];
        @(posedge clk);
        expQ.push_back(k == 2'h3 ? (e & {31'h0, rnd[0]}) : e);
        probeKind <= k;
        @(posedge clk);
        probeKind <= 2'h0;
    endtask
    task ctl(input sr, input [1:0] en, input [7:0] bl, input [7:0] tl);
        ahb(1'b1, sr ? `MBT_OFF_RK_CTRL : `MBT_OFF_CH_CTRL,
            (sr ? 32'h00400000 : 32'h20000000) | {10'h0, en, 4'h0, bl, tl}, 32'h0);
    endtask
    task stopTest;
        $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        if (probeKind != 2'h0 && hreadyout === 1'b1) begin
            seen = probeKind == 2'h1 ? hrdata
                : {31'h0, probeKind == 2'h2 ? throttleStall : isochStall};
            samplesChecked++;
            if (seen !== expQ[0]) begin
                mismatches++;
                $display("MISMATCH %s expected %h seen %h", nm[probeKind], expQ[0], seen);
            end
            void'(expQ.pop_front());
        end
    end
    initial begin
        #400000;
        mismatches++;
        $display("watchdog expired");
        stopTest;
    end

    // ****************
    // tests
    // ****************
    initial begin
        rnd = $urandom(27);
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            d = $urandom & 32'h7f7fffff;
            ahb(1'b0, adr[i], 32'h0, 32'h0);
            ahb(1'b1, adr[i], d, 32'h0);
            ahb(1'b0, adr[i], 32'h0, d & msk[i]);
        end
        $display("test registers done");
        ahb(1'b1, `MBT_OFF_CH_WEIGHTS, 32'h40201008, 32'h0);
        ahb(1'b1, `MBT_OFF_RK_PASSIVE, 32'h04302010, 32'h0);
        ahb(1'b1, `MBT_OFF_RK_ACTIVE_LO, 32'h18142838, 32'h0);
        ahb(1'b1, `MBT_OFF_RK_ACTIVE_HI, 32'h00005048, 32'h0);
        for (i = 0; i < 19; i++) begin
            r = $urandom % 4;
            w = {24'h0, cs[i][7:0]};
            cmdR <= cs[i][14:12];
            fltR <= cs[i][8];
            rkR <= r[1:0];
            odtR <= {3'h0, cs[i][11]} << r;
            pgR <= {3'h0, cs[i][10]} << r;
            pdR <= ~({3'h0, ~cs[i][9]} << r);
            ahb(1'b1, cs[i][15] ? `MBT_OFF_CH_CTRL : `MBT_OFF_RK_CTRL, 32'h0, 32'h0);
            ctl(cs[i][15], 2'b10, w[7:0], 8'hff);
            repeat (1200) @(posedge clk);
            chk(2'h2, 32'h1);
            chk(2'h3, {31'h0, cs[i][15]});
            ctl(cs[i][15], 2'b10, w[7:0] + 8'h01, 8'hff);
            repeat (8) @(posedge clk);
            chk(2'h2, 32'h0);
        end
        ahb(1'b1, `MBT_OFF_RK_CTRL, 32'h0, 32'h0);
        cmdR <= `MBT_CMD_READ;
        ahb(1'b1, `MBT_OFF_CH_CTRL, 32'h00230100, 32'h0);
        repeat (1200) @(posedge clk);
        chk(2'h2, 32'h0);
        ctl(1'b0, 2'b10, 8'h00, 8'hff);
        repeat (8) @(posedge clk);
        chk(2'h2, 32'h1);
        $display("test filters done");
        rkR <= 2'h0;
        odtR <= 4'h0;
        pgR <= 4'h0;
        pdR <= 4'he;
        for (s = 0; s < 2; s++) begin
            w = s ? 32'h70 : 32'h40;
            ahb(1'b1, s ? `MBT_OFF_CH_CTRL : `MBT_OFF_RK_CTRL, 32'h0, 32'h0);
            for (i = 0; i < 4; i++) begin
                d = {28'h0, thStep[i]};
                thermTripPin <= d[1];
                ctl(s[0], d[3:2], w[7:0] + 8'h01, w[7:0]);
                repeat (i == 0 ? 1200 : 20) @(posedge clk);
                chk(2'h2, {31'h0, d[0]});
                chk(2'h3, s ? {31'h0, d[0]} : 32'h0);
            end
        end
        $display("test thermal done");
        thermTripPin <= 1'b0;
        ahb(1'b1, `MBT_OFF_CH_CTRL, 32'h80200000, 32'h0);
        ahb(1'b1, `MBT_OFF_RK_CTRL, 32'h00800000, 32'h0);
        for (i = 0; i < 7; i++) ahb(1'b1, adr[i], 32'h0, 32'h0);
        for (i = 0; i < 7; i++) ahb(1'b0, adr[i], 32'h0, lkExp[i]);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 7; i++) ahb(1'b0, adr[i], 32'h0, 32'h0);
        $display("test locks done");
        stopTest;
    end
endmodule // mbt_throttle_tb
